/* File: hpes_top.v */
`include "hpes_defines.vh"
// Purpose: hot-plug event signalling for all downstream ports
// Assumes: event pulses come from the expander poller on the same clock
// Notes: message generation itself lives outside; this gives request levels
module hpes_top #(
  parameter NPORTS = `HPES_NPORTS
) (
  input wire i_clk,
  input wire i_arst_n,
  input wire [NPORTS*`HPES_NEVT-1:0] i_slot_event,
  input wire [NPORTS*`HPES_NEVT-1:0] i_slot_status_clr,
  input wire [NPORTS*`HPES_NEVT-1:0] i_slot_event_en,
  input wire [NPORTS-1:0] i_hotplug_int_enable,
  input wire i_cc_from_eeprom,
  input wire [NPORTS-1:0] i_port_d3hot,
  input wire i_switch_d3hot,
  input wire [NPORTS-1:0] i_msi_enable,
  input wire [NPORTS-1:0] i_legacy_int_disable,
  input wire [NPORTS-1:0] i_general_event_control,
  input wire [NPORTS-1:0] i_general_event_status_clr,
  input wire [NPORTS-1:0] i_other_int_req,
  input wire [NPORTS-1:0] i_other_wake_req,
  input wire i_gpio_alt_sel,
  input wire i_gpio_out,
  input wire i_gpio_oe,
  input wire i_smb_scl_in,
  input wire i_smb_sda_in,
  input wire i_smb_scl_out,
  input wire i_smb_scl_oe,
  input wire i_smb_sda_out,
  input wire i_smb_sda_oe,
  output wire o_smb_scl_sync,
  output wire o_smb_sda_sync,
  output wire o_smb_scl_out,
  output wire o_smb_scl_oe,
  output wire o_smb_sda_out,
  output wire o_smb_sda_oe,
  output reg [NPORTS*`HPES_NEVT-1:0] o_slot_status,
  output reg [NPORTS-1:0] o_msi_req,
  output reg [NPORTS-1:0] o_intx_req,
  output reg [NPORTS-1:0] o_pme_req,
  output reg [NPORTS-1:0] o_general_event_status,
  output reg o_general_event_out,
  output wire o_gpio5_out,
  output wire o_gpio5_oe
);
  // ***********************************************************
  // per-port controllers
  // ***********************************************************
  wire [NPORTS*`HPES_NEVT-1:0] slot_status;
  wire [NPORTS-1:0] int_req;
  wire [NPORTS-1:0] wake_req;
  wire [NPORTS-1:0] gpe_req;
  wire [NPORTS-1:0] d3hot;
  reg [NPORTS-1:0] next_gpe_status;
  reg [NPORTS-1:0] gpe_req_q;

  assign d3hot = i_port_d3hot | {NPORTS{i_switch_d3hot}}; // R5

  genvar g;
  generate
    for (g = 0; g < NPORTS; g = g + 1)
    begin : g_port // R18
      hpes_port u_port (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_evt_set(i_slot_event[g*`HPES_NEVT +: `HPES_NEVT]),
        .i_cc_from_eeprom(i_cc_from_eeprom),
        .i_evt_clr(i_slot_status_clr[g*`HPES_NEVT +: `HPES_NEVT]),
        .i_evt_en(i_slot_event_en[g*`HPES_NEVT +: `HPES_NEVT]),
        .i_hotplug_int_enable(i_hotplug_int_enable[g]),
        .i_d3hot(d3hot[g]),
        .i_gpe_ctl(i_general_event_control[g]),
        .o_slot_status(slot_status[g*`HPES_NEVT +: `HPES_NEVT]),
        .o_int_req(int_req[g]),
        .o_wake_req(wake_req[g]),
        .o_gpe_req(gpe_req[g])
      );
    end
  endgenerate

  // ***********************************************************
  // general event status and output
  // ***********************************************************
  // status sets on a rising request; set beats a clear
  always @*
  begin
    next_gpe_status = (o_general_event_status & ~i_general_event_status_clr)
      | (gpe_req & ~gpe_req_q & i_general_event_control); // R13 R14
  end

  // ***********************************************************
  // registered request outputs
  // ***********************************************************
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      gpe_req_q <= {NPORTS{1'b0}};
      o_slot_status <= {NPORTS*`HPES_NEVT{1'b0}};
      o_msi_req <= {NPORTS{1'b0}};
      o_intx_req <= {NPORTS{1'b0}};
      o_pme_req <= {NPORTS{1'b0}};
      o_general_event_status <= {NPORTS{1'b0}};
      o_general_event_out <= 1'b0;
    end
    else
    begin
      gpe_req_q <= gpe_req;
      o_slot_status <= slot_status; // R15
      // msi wins when enabled; intx only if not disabled
      o_msi_req <= (int_req & i_msi_enable) | (i_other_int_req & i_msi_enable); // R4 R16
      o_intx_req <= (int_req | i_other_int_req) & ~i_msi_enable
        & ~i_legacy_int_disable; // R4 R16
      o_pme_req <= wake_req | i_other_wake_req; // R5 R6 R16
      o_general_event_status <= next_gpe_status; // R13
      o_general_event_out <= |next_gpe_status; // R11 R20
    end
  end

  // ***********************************************************
  // pins: gpio5 and master bus, released during reset
  // ***********************************************************
  // a pin held released in reset is safe for hot insertion
  assign o_gpio5_out = i_gpio_alt_sel ? o_general_event_out : i_gpio_out; // R9 R12
  assign o_gpio5_oe = i_arst_n & (i_gpio_alt_sel | i_gpio_oe); // R12 R17

  // expander traffic is passed through; polling protocol is outside
  assign o_smb_scl_out = i_smb_scl_out; // R1
  assign o_smb_sda_out = i_smb_sda_out; // R1
  assign o_smb_scl_oe = i_arst_n & i_smb_scl_oe; // R1 R17
  assign o_smb_sda_oe = i_arst_n & i_smb_sda_oe; // R1 R17

  hpes_sync #(
    .WIDTH(2)
  ) u_smb_sync (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_d({i_smb_scl_in, i_smb_sda_in}),
    .o_q({o_smb_scl_sync, o_smb_sda_sync})
  );
endmodule // hpes_top

/* File: hpes_defines.vh */
// Purpose: constants for the hot-plug event signalling block
// Assumes: plain Verilog-2005, one clock, no register bus
// Notes: slot bit positions follow the slot status/control layout
//
// Behaviour
// [R1] sensor inputs and indicator outputs pass through external expanders on master bus
// [R2] hot-plug interrupt raised only while the port's global enable is set
// [R3] each of five slot events requests interrupt unless its enable or global masks
// [R4] unmasked interrupt goes out as msi or legacy intx per command bits
// [R5] in d3hot, unmasked event with global enable clear sends wake message only
// [R6] in d3hot, unmasked event with global enable set sends wake and interrupt
// [R7] in d3hot, an individually masked event sends neither wake nor interrupt
// [R8] command completed never causes a wake message, may still interrupt
// [R9] general event output offered as gpio alternate function for legacy systems
// [R10] port's general event control bit suppresses its intx, msi and wake
// [R11] port in general event mode reports each event on general event output
// [R12] gpio pin shows general event only when set to its alternate function
// [R13] asserting general event for a port sets that port's status bit
// [R14] general event status bit sets only for ports in general event mode
// [R15] general event mode leaves slot status and mask bits working unchanged
// [R16] non hot-plug interrupt and wake sources pass through unaffected
// [R17] during reset all i/o outputs are held released, not driven
// [R18] one controller and one control/status bit per downstream port 1..15
// [R19] command completed not set by eeprom initialisation of hot-plug registers
// [R20] general event output stays asserted while any status bit is set
`ifndef HPES_DEFINES_VH
`define HPES_DEFINES_VH
`define HPES_NPORTS 15
`define HPES_NEVT 5
// event bit positions inside the per-port event vector
`define HPES_EVT_BTN_BIT 0
`define HPES_EVT_FAULT_BIT 1
`define HPES_EVT_LATCH_BIT 2
`define HPES_EVT_PRES_BIT 3
`define HPES_EVT_CMD_BIT 4
`define HPES_EVT_NONE 5'h00
`define HPES_WAKE_MASK 5'h0f
`define HPES_GPIO_ALT_BIT 5
`endif

/* File: hpes_sync.v */
// Purpose: two-flop synchroniser for a bus of levels
// Assumes: inputs are from outside the clock domain
// Notes: first stage is read only by the second stage
module hpes_sync #(
  parameter WIDTH = 1
) (
  input wire i_clk,
  input wire i_arst_n,
  input wire [WIDTH-1:0] i_d,
  output wire [WIDTH-1:0] o_q
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;

  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1 <= i_d;
      stage2 <= stage1;
    end
  end

  assign o_q = stage2;
endmodule // hpes_sync

/* File: hpes_port.v */
`include "hpes_defines.vh"
// Purpose: per-port slot status latching and event routing
// Assumes: slot event pulses come from the expander poller, same clock
// Notes: general event mode only changes where events are sent
module hpes_port (
  input wire i_clk,
  input wire i_arst_n,
  input wire [`HPES_NEVT-1:0] i_evt_set,
  input wire i_cc_from_eeprom,
  input wire [`HPES_NEVT-1:0] i_evt_clr,
  input wire [`HPES_NEVT-1:0] i_evt_en,
  input wire i_hotplug_int_enable,
  input wire i_d3hot,
  input wire i_gpe_ctl,
  output wire [`HPES_NEVT-1:0] o_slot_status,
  output wire o_int_req,
  output wire o_wake_req,
  output wire o_gpe_req
);
  reg [`HPES_NEVT-1:0] slot_status;
  wire [`HPES_NEVT-1:0] set_mask;
  wire [`HPES_NEVT-1:0] unmasked;
  wire any_int;
  wire any_wake;

  // eeprom loading of the registers must not flag command completed
  assign set_mask = i_cc_from_eeprom ?
    (i_evt_set & ~(`HPES_NEVT'h1 << `HPES_EVT_CMD_BIT)) : i_evt_set; // R19

  // set wins over a software clear in the same cycle
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      slot_status <= `HPES_EVT_NONE;
    else
      slot_status <= (slot_status & ~i_evt_clr) | set_mask; // R15
  end

  assign unmasked = slot_status & i_evt_en; // R3 R7
  assign any_int = (|unmasked) & i_hotplug_int_enable; // R2 R3 R6
  assign any_wake = (|(unmasked & `HPES_WAKE_MASK)) & i_d3hot; // R5 R6 R8

  assign o_slot_status = slot_status;
  assign o_int_req = any_int & ~i_gpe_ctl; // R10
  assign o_wake_req = any_wake & ~i_gpe_ctl; // R10
  // legacy mode reports every unmasked event, independent of global enable
  assign o_gpe_req = (|unmasked) & i_gpe_ctl; // R11 R14
endmodule // hpes_port

/* File: hpes_top_asserts.sv */
// Purpose: port-level assertions for hot-plug event signalling
// Assumes: one clock, async active-low reset
// Notes: masks allow up to two cycles of request latency
module hpes_top_asserts #(
  parameter NPORTS = 15
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [NPORTS*5-1:0] i_slot_event,
  input wire logic [NPORTS-1:0] i_general_event_control,
  input wire logic [NPORTS-1:0] i_other_int_req,
  input wire logic i_gpio_alt_sel,
  input wire logic i_gpio_out,
  input wire logic i_gpio_oe,
  input wire logic [NPORTS*5-1:0] o_slot_status,
  input wire logic [NPORTS-1:0] o_msi_req,
  input wire logic [NPORTS-1:0] o_intx_req,
  input wire logic [NPORTS-1:0] o_general_event_status,
  input wire logic o_general_event_out,
  input wire logic o_gpio5_out,
  input wire logic o_gpio5_oe,
  input wire logic o_smb_scl_oe,
  input wire logic o_smb_sda_oe
);
  default clocking chk_cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);
  sequence status_up;
    ##[1:2] o_slot_status[0];
  endsequence
  status_rise_a:
    assert property (i_slot_event[0] |-> status_up) else $error("no latch");
  // reset itself is the cause here, so no disable
  reset_release_a:
    assert property (disable iff (1'b0) !i_arst_n |->
      !(o_gpio5_oe || o_smb_scl_oe || o_smb_sda_oe)) else $error("oe in reset");
  msi_excl_a:
    assert property ((o_msi_req & o_intx_req) == '0) else $error("msi and intx");
  gpe_or_a:
    assert property (o_general_event_out == |o_general_event_status)
    else $error("gpe out");
  gpe_gate_a:
    assert property ((o_general_event_status & ~$past(o_general_event_status)
      & ~$past(i_general_event_control)
      & ~$past(i_general_event_control, 2)) == '0) else $error("gpe set");
  gpe_quiet_a:
    assert property (((o_msi_req | o_intx_req) & $past(i_general_event_control)
      & $past(i_general_event_control, 2) & ~$past(i_other_int_req)
      & ~$past(i_other_int_req, 2)) == '0) else $error("gpe int");
  gpio_plain_a:
    assert property (!i_gpio_alt_sel |-> o_gpio5_out == i_gpio_out
      && o_gpio5_oe == i_gpio_oe) else $error("gpio plain");
  gpio_alt_a:
    assert property (i_gpio_alt_sel |-> o_gpio5_out == o_general_event_out)
    else $error("gpio alt");
endmodule // hpes_top_asserts

bind hpes_top hpes_top_asserts #(.NPORTS(NPORTS)) u_hpes_chk (.*);

/* File: hpes_host_model.sv */
// Purpose: host sink counting interrupt and wake messages
// Assumes: request levels, one message per cycle with any rising request
// Notes: never pushes back, as the real host cannot
module hpes_host_model (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [14:0] i_msi_req,
  input wire logic [14:0] i_intx_req,
  input wire logic [14:0] i_pme_req,
  output logic [15:0] o_msg_cnt
);
  logic [44:0] last;
  always @(posedge i_clk or negedge i_arst_n)
    if (!i_arst_n)
    begin
      last <= '0;
      o_msg_cnt <= '0;
    end
    else
    begin
      last <= {i_msi_req, i_intx_req, i_pme_req};
      if (|({i_msi_req, i_intx_req, i_pme_req} & ~last))
        o_msg_cnt <= o_msg_cnt + 16'h0001;
    end
endmodule // hpes_host_model

/* File: hotplug_event_signalling_bench.sv */
// Purpose: random self-checking bench for hot-plug event signalling
// Assumes: outputs settle within three edges of an event
// Notes: one port and event per test, the rest randomised
module hotplug_event_signalling_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_arst_n, i_cc_from_eeprom, i_switch_d3hot, i_gpio_alt_sel;
  logic i_gpio_out, i_gpio_oe, i_smb_scl_in, i_smb_sda_in, i_smb_scl_out;
  logic i_smb_scl_oe, i_smb_sda_out, i_smb_sda_oe, o_general_event_out;
  logic o_gpio5_out, o_gpio5_oe, o_smb_scl_sync, o_smb_sda_sync;
  logic o_smb_scl_out, o_smb_scl_oe, o_smb_sda_out, o_smb_sda_oe;
  logic hp, d3, en, ge, ee, me, dis, st, u, irq;
  logic [74:0] i_slot_event, i_slot_status_clr, i_slot_event_en, o_slot_status;
  logic [14:0] i_hotplug_int_enable, i_port_d3hot, i_msi_enable, o_msi_req;
  logic [14:0] i_legacy_int_disable, i_general_event_control, o_intx_req;
  logic [14:0] i_general_event_status_clr, i_other_int_req, o_pme_req;
  logic [14:0] i_other_wake_req, o_general_event_status;
  logic [15:0] msg_cnt;
  logic [31:0] rs = 32'h00016cb7;
  int error_cnt = 0, samples_checked = 0, k, p, e, c, m;
  hpes_top i_hpes_top (.*);
  hpes_host_model i_hpes_host_model (.i_clk, .i_arst_n, .i_msi_req(o_msi_req),
    .i_intx_req(o_intx_req), .i_pme_req(o_pme_req), .o_msg_cnt(msg_cnt));
  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [14:0] pb(input logic [14:0] v, input logic b);
    v[p] = b;
    return v;
  endfunction
  task chk(input logic [7:0] seen, input logic [7:0] want);
    samples_checked++;
    if (seen !== want)
      $display("Error %0t: saw %h want %h", $time, seen, want);
    if (seen !== want)
      error_cnt++;
  endtask
  task tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    {i_slot_event, i_slot_status_clr, i_slot_event_en, i_hotplug_int_enable,
     i_port_d3hot, i_msi_enable, i_legacy_int_disable, i_general_event_control,
     i_general_event_status_clr, i_other_int_req, i_other_wake_req,
     i_cc_from_eeprom, i_switch_d3hot, i_gpio_alt_sel, i_gpio_out, i_smb_scl_in,
     i_smb_sda_in, i_smb_scl_out, i_smb_sda_out} = '0;
    // oe requests high during reset so that release is visible
    {i_gpio_oe, i_smb_scl_oe, i_smb_sda_oe, i_arst_n} = 4'he;
    tick(4);
    #1 chk({5'h00, o_gpio5_oe, o_smb_scl_oe, o_smb_sda_oe}, 8'h00);
    tick(1);
    i_arst_n <= 1'b1;
    // first 80 tests sweep every event against every hp, d3, en and ge setting
    for (k = 0; k < 120; k++)
    begin
      rs = xs(rs);
      // both ends of the port range first, then random ports
      p = (k < 5) ? 0 : (k < 10) ? 14 : rs[7:4] % 15;
      e = (k < 80) ? k % 5 : rs[10:8] % 5;
      c = (k < 80) ? k / 5 : rs[14:11];
      {hp, d3, en, ge} = c[3:0];
      {ee, me, dis} = rs[17:15];
      tick(1);
      i_slot_event_en <= {rs[10:0], rs, rs} & ~(75'h1 << (5 * p + e))
        | ({74'h0, en} << (5 * p + e));
      i_hotplug_int_enable <= pb(rs[14:0], hp);
      i_port_d3hot <= pb(rs[16:2], d3 & rs[20]);
      i_switch_d3hot <= d3 & !rs[20];
      i_msi_enable <= pb(rs[19:5], me);
      i_legacy_int_disable <= pb(rs[21:7], dis);
      i_general_event_control <= pb(rs[23:9], ge);
      i_other_int_req <= pb(rs[25:11], 1'b0);
      i_other_wake_req <= pb(rs[27:13], 1'b0);
      i_cc_from_eeprom <= ee;
      {i_gpio_alt_sel, i_gpio_out, i_gpio_oe, i_smb_scl_in, i_smb_sda_in,
       i_smb_scl_out, i_smb_scl_oe, i_smb_sda_out, i_smb_sda_oe} <= rs[31:23];
      tick(1);
      i_slot_event[5 * p + e] <= 1'b1;
      tick(1);
      i_slot_event <= '0;
      tick(1);
      // other ports' request changes are already counted here
      m = msg_cnt;
      tick(2);
      st = !(ee && e == 4);
      u = en && st;
      irq = u && hp && !ge;
      #1 chk({2'h0, o_general_event_status[p], o_general_event_out,
        o_msi_req[p], o_intx_req[p], o_pme_req[p], o_slot_status[5 * p + e]},
        {2'h0, u && ge, u && ge, irq && me, irq && !me && !dis,
        u && d3 && e != 4 && !ge, st});
      chk(8'(msg_cnt - m), {7'h0, irq && (me || !dis)
        || u && d3 && e != 4 && !ge});
      chk({o_smb_scl_sync, o_smb_sda_sync, o_smb_scl_out, o_smb_sda_out,
        o_smb_scl_oe, o_smb_sda_oe, o_gpio5_out, o_gpio5_oe},
        {i_smb_scl_in, i_smb_sda_in, i_smb_scl_out, i_smb_sda_out,
        i_smb_scl_oe, i_smb_sda_oe, i_gpio_alt_sel ? u && ge : i_gpio_out,
        i_gpio_alt_sel | i_gpio_oe});
      tick(1);
      i_slot_status_clr <= '1;
      i_general_event_status_clr <= '1;
      tick(1);
      i_slot_status_clr <= '0;
      i_general_event_status_clr <= '0;
      tick(3);
      #1 chk({5'h00, o_general_event_out, o_msi_req[p], o_pme_req[p]}, 8'h00);
      $display("test %0d done", k);
    end
    end_sim;
  end
endmodule // hotplug_event_signalling_bench
